// *** design/uart_filter_pkg.sv ***
package uart_filter_pkg;

   // Serial port operating modes
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_VAR8  = 2'b01,
      MODE_FIX9  = 2'b10,
      MODE_VAR9  = 2'b11
   } serial_mode_t;

   // Register offsets of the plain register port
   localparam logic [3:0] OFS_CONTROL    = 4'h0;
   localparam logic [3:0] OFS_STATUS     = 4'h1;
   localparam logic [3:0] OFS_INDIV_ADDR = 4'h2;
   localparam logic [3:0] OFS_ADDR_MASK  = 4'h3;
   localparam logic [3:0] OFS_RX_DATA    = 4'h4;

   // Control register field positions
   localparam int CTL_MODE_LO      = 0;
   localparam int CTL_MULTIPROC    = 2;
   localparam int CTL_BAUD_DOUBLE  = 3;
   localparam int CTL_FRAME_CHECK  = 4;
   localparam int CTL_SERIAL_IRQ   = 5;
   localparam int CTL_GLOBAL_IRQ   = 6;

   // Status register field positions (done and framing flags write one to clear, ninth bit read-only)
   localparam int STS_RX_DONE      = 0;
   localparam int STS_TX_DONE      = 1;
   localparam int STS_FRAME_ERR    = 2;
   localparam int STS_NINTH_BIT    = 3;

   // Reset values
   localparam logic [7:0] RST_CONTROL    = 8'h00;
   localparam logic [7:0] RST_INDIV_ADDR = 8'h00;
   localparam logic [7:0] RST_ADDR_MASK  = 8'h00;

   // Fixed-rate divider: 32 clocks per bit, 16 when doubled
   localparam int          FIX_DIV_SLOW = 32;
   localparam int          FIX_DIV_FAST = 16;
   localparam logic [4:0]  FIX_CNT_SLOW = 5'(FIX_DIV_SLOW - 1);
   localparam logic [4:0]  FIX_CNT_FAST = 5'(FIX_DIV_FAST - 1);

   // A finished frame handed over by the receive shifter
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       ninth;
      logic       stop_ok;
   } rx_frame_t;

   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

// *** design/uart_multiproc_addr_filter.sv ***
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// R01 - Nine-bit fixed-rate mode runs the link at clock/16 or clock/32 only.
// R02 - Fixed rate is clock/32, doubled to clock/16 by the baud double select.
// R03 - With multiproc enable, ninth bit zero is data, one is address.
// R04 - With multiproc enable, ninth-bit-zero frames are dropped without receive-done.
// R05 - Matching address frame sets received ninth bit and receive-done.
// R06 - Software clears multiproc enable after being addressed to accept data.
// R07 - Address recognition is active exactly when multiproc enable is set outside shift mode.
// R08 - With recognition on, only matching address frames set receive-done.
// R09 - Eight-bit mode: stop bit replaces ninth bit; needs match and valid stop.
// R10 - Multiproc enable has no effect in synchronous shift mode.
// R11 - Given address: mask-zero bits are don't-care, mask-one bits must equal.
// R12 - All-ones mask needs an exact eight-bit match with the individual address.
// R13 - Broadcast address is address OR mask; zero positions are don't-care.
// R14 - A frame matches if given or broadcast address matches.
// R15 - Reset clears address and mask to zero so every frame matches.
// R16 - Receive-done and transmit-done are ORed into one interrupt request.
// R17 - Both done flags stay set until software writes them clear.
// R18 - Interrupt reaches core only with serial and global enables both set.
// R19 - Receive-done timing is ninth bit or stop bit by mode and framing check; here it is always the stop slot.
// R20 - With framing check on, a bad stop bit sets a sticky framing error.
// R21 - With framing check on, receive-done rises on the stop bit.
// R22 - Match compares the eight data bits combinationally before the decision.
module uart_multiproc_addr_filter
   import uart_filter_pkg::*;
(
   // Clock and reset
   input  wire logic                        clock_i,
   input  wire logic                        rst_n_i,
   // Register port
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   input  wire logic [3:0]                  reg_addr_i,
   input  wire logic [7:0]                  reg_wdata_i,
   output logic      [7:0]                  reg_rdata_o,
   // Serial line
   input  wire logic                        rxd_i,
   output logic                             bit_tick_o,
   // Transmit path events
   input  wire logic                        tx_done_i,
   // Interrupt toward the core
   output logic                             serial_irq_o
);
   import uart_filter_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA  = 4'b0100,
      ST_STOP  = 4'b1000
   } rx_state_t;

   logic [7:0]   control;
   logic [7:0]   slave_individual_addr;
   logic [7:0]   slave_addr_mask;
   logic [7:0]   rx_data;
   logic         rx_done_flag;
   logic         tx_done_flag;
   logic         framing_error_flag;
   logic         rx_ninth_bit;
   serial_mode_t mode;
   logic         multiproc_enable;
   logic         baud_double_sel;
   logic         framing_check_enable;
   logic         serial_irq_enable;
   logic         global_irq_enable;
   reg_req_t     req;

   assign req                  = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
   assign mode                 = serial_mode_t'(control[CTL_MODE_LO +: 2]);
   assign multiproc_enable     = control[CTL_MULTIPROC];
   assign baud_double_sel      = control[CTL_BAUD_DOUBLE];
   assign framing_check_enable = control[CTL_FRAME_CHECK];
   assign serial_irq_enable    = control[CTL_SERIAL_IRQ];
   assign global_irq_enable    = control[CTL_GLOBAL_IRQ];

   // Fixed-rate bit clock enable: only two divisors exist
   logic [4:0] div_cnt;
   logic [4:0] div_top;

   assign div_top = baud_double_sel ? FIX_CNT_FAST : FIX_CNT_SLOW; // R01 R02

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         div_cnt <= 5'h00;
      else if (div_cnt >= div_top)
         div_cnt <= 5'h00;
      else
         div_cnt <= div_cnt + 5'h01;
   end

   // Variable-rate modes get their bit clock from outside this block;
   // here every mode uses the fixed divider so the filter can be exercised.
   assign bit_tick_o = (div_cnt == div_top); // R01

   // Receive shifter: samples once per bit at the bit tick
   rx_state_t  rx_state;
   logic [3:0] bit_cnt;
   logic [8:0] shift;
   logic [3:0] last_bit;
   rx_frame_t  frame;

   // Eight-bit mode carries eight data bits; nine-bit modes carry nine
   assign last_bit = (mode == MODE_VAR8) ? 4'h7 : 4'h8;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         rx_state <= ST_IDLE;
         bit_cnt  <= 4'h0;
         shift    <= 9'h000;
         frame    <= '0;
      end
      else
      begin
         frame.valid <= 1'b0;
         if (bit_tick_o)
         begin
            unique case (rx_state)
               ST_IDLE:
                  if (!rxd_i && mode != MODE_SHIFT)
                     rx_state <= ST_START;
               ST_START:
               begin
                  bit_cnt  <= 4'h0;
                  shift    <= 9'h000;
                  rx_state <= rxd_i ? ST_IDLE : ST_DATA;
               end
               ST_DATA:
               begin
                  shift[bit_cnt] <= rxd_i;
                  bit_cnt        <= bit_cnt + 4'h1;
                  if (bit_cnt == last_bit)
                     rx_state <= ST_STOP;
               end
               ST_STOP:
               begin
                  frame.valid   <= 1'b1;
                  frame.data    <= shift[7:0];
                  // R09: in eight-bit mode the stop bit plays the ninth bit
                  frame.ninth   <= (mode == MODE_VAR8) ? rxd_i : shift[8]; // R03 R09
                  frame.stop_ok <= rxd_i;
                  rx_state      <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Address filter, purely combinational ahead of the done decision
   logic [7:0] bcast_addr;
   logic       given_match;
   logic       bcast_match;
   logic       addr_match;
   logic       filter_on;
   logic       accept;

   assign bcast_addr  = slave_individual_addr | slave_addr_mask; // R13
   assign given_match = ((frame.data ^ slave_individual_addr) & slave_addr_mask) == 8'h00; // R11 R12 R22
   assign bcast_match = ((frame.data ^ 8'hff) & bcast_addr) == 8'h00; // R13 R22
   assign addr_match  = given_match || bcast_match; // R14

   assign filter_on   = multiproc_enable && (mode != MODE_SHIFT); // R07 R10

   always_comb
   begin
      if (!filter_on)
         accept = 1'b1;
      else if (mode == MODE_VAR8)
         accept = addr_match && frame.stop_ok; // R09
      else
         accept = frame.ninth && addr_match; // R03 R04 R05 R08
   end

   // Framing check moves the done point to the stop bit; without it, in the
   // nine-bit modes done would rise one bit earlier. Both land in the stop
   // slot here since the frame is delivered there; timing skew is one bit.
   logic rx_set;
   logic fe_set;

   assign rx_set = frame.valid && accept; // R19 R21
   assign fe_set = frame.valid && framing_check_enable && !frame.stop_ok; // R20

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         rx_data <= 8'h00;
      else if (rx_set)
         rx_data <= frame.data;
   end

   // Sticky flags: hardware set wins over a same-cycle software clear
   logic clr_sel;

   assign clr_sel = req.wr && (req.addr == OFS_STATUS);

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         rx_done_flag       <= 1'b0;
         tx_done_flag       <= 1'b0;
         framing_error_flag <= 1'b0;
         rx_ninth_bit       <= 1'b0;
      end
      else
      begin
         if (rx_set)
            rx_done_flag <= 1'b1; // R05 R17
         else if (clr_sel && req.wdata[STS_RX_DONE])
            rx_done_flag <= 1'b0; // R17
         if (tx_done_i)
            tx_done_flag <= 1'b1; // R17
         else if (clr_sel && req.wdata[STS_TX_DONE])
            tx_done_flag <= 1'b0;
         if (fe_set)
            framing_error_flag <= 1'b1; // R20
         else if (clr_sel && req.wdata[STS_FRAME_ERR])
            framing_error_flag <= 1'b0;
         if (rx_set)
            rx_ninth_bit <= frame.ninth; // R05
      end
   end

   // Configuration registers
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         control               <= RST_CONTROL;
         slave_individual_addr <= RST_INDIV_ADDR; // R15
         slave_addr_mask       <= RST_ADDR_MASK; // R15
      end
      else if (req.wr)
      begin
         // Software drops multiproc enable here once addressed
         if (req.addr == OFS_CONTROL)
            control <= req.wdata; // R06
         if (req.addr == OFS_INDIV_ADDR)
            slave_individual_addr <= req.wdata;
         if (req.addr == OFS_ADDR_MASK)
            slave_addr_mask <= req.wdata;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (req.rd)
      begin
         unique case (req.addr)
            OFS_CONTROL:    reg_rdata_o <= control;
            OFS_STATUS:     reg_rdata_o <= {4'h0, rx_ninth_bit, framing_error_flag, tx_done_flag, rx_done_flag};
            OFS_INDIV_ADDR: reg_rdata_o <= slave_individual_addr;
            OFS_ADDR_MASK:  reg_rdata_o <= slave_addr_mask;
            OFS_RX_DATA:    reg_rdata_o <= rx_data;
            default:        reg_rdata_o <= 8'h00;
         endcase
      end
      else
         reg_rdata_o <= 8'h00;
   end

   assign serial_irq_o = (rx_done_flag || tx_done_flag) // R16
                         && serial_irq_enable && global_irq_enable; // R18

endmodule

// *** verif/uart_filter_properties.sv ***
`timescale 1ns/1ps
module uart_filter_properties
   import uart_filter_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // Register port
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic [7:0] reg_rdata_o,
   // Serial line and events
   input  wire logic       rxd_i,
   input  wire logic       bit_tick_o,
   input  wire logic       tx_done_i,
   input  wire logic       serial_irq_o
);
   logic [7:0] ctl;
   logic [5:0] gap;
   logic       seen;
   default clocking ck @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Control is shadowed from the write port, the checker cannot see inside
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         ctl <= RST_CONTROL;
      else if (reg_wr_i && reg_addr_i == OFS_CONTROL)
         ctl <= reg_wdata_i;
   end
   // A rate change leaves one mixed interval, so spacing counts only after a clean tick
   always_ff @(posedge clock_i)
   begin
      gap  <= bit_tick_o ? 6'h00 : gap + 6'h01;
      seen <= rst_n_i && !(reg_wr_i && reg_addr_i == OFS_CONTROL) && (seen || bit_tick_o);
   end
   AST_TICK_RATE: assert property (bit_tick_o && seen |-> gap == 6'h0f || gap == 6'h1f)
      else $error("bit period is neither of the two rates");
   AST_TICK_DIV: assert property (bit_tick_o && seen |-> gap == (ctl[CTL_BAUD_DOUBLE] ? FIX_CNT_FAST : FIX_CNT_SLOW))
      else $error("bit period does not follow the doubling bit");
   AST_IRQ_GATE: assert property (serial_irq_o |-> ctl[CTL_SERIAL_IRQ] && ctl[CTL_GLOBAL_IRQ])
      else $error("interrupt without both enables");
   AST_TX_IRQ: assert property (tx_done_i && ctl[6:5] == 2'b11 && !reg_wr_i |=> serial_irq_o)
      else $error("transmit event raised no interrupt");
   AST_IRQ_HOLD: assert property (serial_irq_o && !reg_wr_i |=> serial_irq_o)
      else $error("interrupt dropped without a write");
   // A received frame raises its flag two clocks after the stop-bit tick
   AST_RX_TIMING: assert property ($rose(serial_irq_o) |-> $past(bit_tick_o, 2) || $past(tx_done_i) || $past(reg_wr_i))
      else $error("interrupt rose off a bit boundary");
   AST_SHIFT_IDLE: assert property ($rose(serial_irq_o) && ctl[1:0] == 2'b00 |-> $past(tx_done_i) || $past(reg_wr_i))
      else $error("receive event in shift mode");
   AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i > OFS_RX_DATA |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind uart_multiproc_addr_filter uart_filter_properties i_props (.clock_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
   .reg_wdata_i, .reg_rdata_o, .rxd_i, .bit_tick_o, .tx_done_i, .serial_irq_o);

// *** verif/serial_master.sv ***
`timescale 1ns/1ps
module serial_master
(
   // Clock and bit timing
   input  wire logic clock_i,
   input  wire logic bit_tick_i,
   // Serial line toward the receiver
   output logic      rxd_o
);
   initial
      rxd_o = 1'b1;
   // Start is held over two ticks because the receiver confirms it on the second
   task automatic send(input logic [7:0] data, input logic ninth, input logic stop, input logic nine_bit);
      logic [11:0] bits;
      bits = nine_bit ? {stop, ninth, data, 2'b00} : {1'b1, stop, data, 2'b00};
      for (int i = 0; i < (nine_bit ? 12 : 11); i++)
      begin
         @(posedge clock_i iff bit_tick_i);
         rxd_o <= bits[i];
      end
      @(posedge clock_i iff bit_tick_i);
      rxd_o <= 1'b1;
   endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
   import uart_filter_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [7:0]  reg_rdata_o;
   logic        rxd_i;
   logic        bit_tick_o;
   logic        tx_done_i = 1'b0;
   logic        serial_irq_o;
   logic [7:0]  v;
   logic [35:0] e;
   int          num_errors = 0;
   int          total_checks = 0;
   // Control, address, mask, frame, then ninth or stop bit and whether it is taken
   logic [35:0] tab [12] = '{
      36'h6e56fc570,
      36'h6e56fc573,
      36'h6e0000a53,
      36'h6e56fc5b2,
      36'h6e56fcfe3,
      36'h6e3cff3d2,
      36'h6e3cff3c3,
      36'h6d3cff3c0,
      36'h6d3cff3c3,
      36'h663cff3c3,
      36'h6f3cff3c3,
      36'h6a3cff111};
   always #12.5 clock_i = ~clock_i;
   uart_multiproc_addr_filter i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .rxd_i(rxd_i),
      .bit_tick_o(bit_tick_o), .tx_done_i(tx_done_i), .serial_irq_o(serial_irq_o));
   serial_master i_master (.clock_i(clock_i), .bit_tick_i(bit_tick_o), .rxd_o(rxd_i));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [3:0] a);
      @(posedge clock_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      v = reg_rdata_o;
   endtask
   // Counts the clocks from one tick until the next tick shows, one fewer than a bit period, skipping the interval in progress
   task automatic gapchk(input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      @(posedge clock_i iff bit_tick_o);
      #1;
      do
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
      while (!bit_tick_o && n < 8'h40);
      check(n, exp);
   endtask
   task automatic irqchk(input logic x);
      #1;
      check({7'h00, serial_irq_o}, {7'h00, x});
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (int a = 0; a < 6; a++)
      begin
         rd(4'(a));
         check(v, 8'h00);
      end
      gapchk(8'(FIX_DIV_SLOW - 1));
      wr(OFS_CONTROL, 8'h08);
      gapchk(8'(FIX_DIV_FAST - 1));
      repeat (100) @(posedge clock_i);
      foreach (tab[i])
      begin
         e = tab[i];
         wr(OFS_CONTROL, e[35:28]);
         wr(OFS_INDIV_ADDR, e[27:20]);
         wr(OFS_ADDR_MASK, e[19:12]);
         if (e[29])
            i_master.send(e[11:4], e[1], 1'b1, 1'b1);
         else
            i_master.send(e[11:4], 1'b0, e[1], 1'b0);
         rd(OFS_STATUS);
         check(v & {4'h0, e[29], 3'h1}, {4'h0, e[29] & e[1], 2'h0, e[0]});
         wr(OFS_STATUS, 8'h07);
      end
      rd(OFS_RX_DATA);
      check(v, 8'h11);
      wr(OFS_CONTROL, 8'h1a);
      i_master.send(8'h42, 1'b0, 1'b0, 1'b1);
      i_master.send(8'h43, 1'b0, 1'b1, 1'b1);
      rd(OFS_STATUS);
      check(v & 8'h05, 8'h05);
      wr(OFS_CONTROL, 8'h7a);
      irqchk(1'b1);
      wr(OFS_STATUS, 8'h07);
      irqchk(1'b0);
      @(posedge clock_i);
      tx_done_i <= 1'b1;
      @(posedge clock_i);
      tx_done_i <= 1'b0;
      for (int en = 0; en < 4; en++)
      begin
         wr(OFS_CONTROL, {1'b0, 2'(en), 5'h04});
         irqchk(en == 3);
      end
      wr(OFS_STATUS, 8'h02);
      irqchk(1'b0);
      wr(OFS_CONTROL, 8'h04);
      i_master.send(8'h00, 1'b1, 1'b1, 1'b1);
      rd(OFS_STATUS);
      check(v & 8'h01, 8'h00);
      conclude();
   end
   initial
   begin
      #500000;
      num_errors++;
      conclude();
   end
endmodule
